//--- rtl/wai_pkg.sv
// Constants, register map and carrier types for the weld automation I/O block.
// Assumes a 200 MHz core clock and an Avalon-MM slave with 32-bit data.
// Function
// - Bad output asserts when any measurement crosses a rejection limit.
// - Good output asserts when no measurement crosses a rejection limit.
// - Suspect function asserts when a measurement crosses a suspect limit.
// - Cycle-active function asserts as soon as the welding cycle begins.
// - In maintained mode, cycle-active drops once hold phase has finished.
// - Ultrasound-active function asserts during weld, scrub and afterburst energy.
// - Hold-phase function asserts for the whole hold phase.
// - Ready asserts when the hold phase completes.
// - Afterburst and press return start only after ready is asserted.
// - Network function asserts while the device is an active network node.
// - Initiate must release before cycle end; still active at start raises error 212.
// - Normally-open stop closed ends the cycle, valves off until released.
// - Normally-closed stop open ends the cycle, valves off until closed again.
// - Stopped cycles are not counted in the part count.
// - Press inhibit closed keeps press valves off during a cycle.
// - Output polarity selectable; active-high closes switch; active-high default.
// - Maintained mode holds results from cycle completion to next initiate; default. The code clears them at the next accepted start_req or on any stop.
// - Pulsed mode drives each result as one 100 ms pulse at cycle end.
package wai_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned HOLD_MS         = 100;
  localparam int unsigned HOLD_CYC        = CLK_HZ / 1000 * HOLD_MS;

  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h1;
  localparam logic [3:0]  REG_COUNT       = 4'h2;
  localparam logic [3:0]  REG_ERROR       = 4'h3;

  localparam int unsigned CTRL_POL_LOW    = 0;
  localparam int unsigned CTRL_PULSED     = 1;
  localparam int unsigned CTRL_ALT_LSB    = 2;
  localparam int unsigned CTRL_RDY_LSB    = 4;
  localparam int unsigned CTRL_NET_ACT    = 6;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  localparam logic [15:0] ERR_AUTO_ACTIVE = 16'h00D4;

  typedef enum logic [1:0] {
    ALT_SUSPECT = 2'h0,
    ALT_IN_CYCLE = 2'h1,
    ALT_SONICS = 2'h2,
    ALT_IN_HOLD = 2'h3
  } wai_alt_type;

  typedef enum logic [1:0] {
    RDY_READY = 2'h0,
    RDY_NETWORK = 2'h1,
    RDY_SONICS = 2'h2,
    RDY_RSVD = 2'h3
  } wai_rdy_type;

  // Weld sequence phases, Gray from idle through afterburst to home
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h0,
    PH_WELD  = 3'h1,
    PH_HOLD  = 3'h3,
    PH_AFTER = 3'h2,
    PH_HOME  = 3'h6
  } wai_phase_type;

  typedef struct packed {
    logic initiate;
    logic stop_no;
    logic stop_nc_closed;
    logic inhibit;
  } wai_contacts_type;

  typedef struct packed {
    logic bad;
    logic suspect_pos;
    logic good;
    logic ready_pos;
  } wai_outputs_type;

  typedef struct packed {
    logic        sonics;
    logic        valves;
    logic        afterburst;
    logic        press_return;
  } wai_drive_type;

endpackage

//--- rtl/wai_pulse_timer.sv
// One-shot timer: holds busy for a fixed number of core clock cycles.
// Assumes start is a single-cycle pulse in the core clock domain.
`timescale 1ns/1ps
module wai_pulse_timer
  import wai_pkg::*;
#(
  parameter int unsigned CYCLES = HOLD_CYC
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic start,
  output logic      busy
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r;

  // Restart on a new start extends the pulse
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= CW'(CYCLES);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  assign busy = (cnt_r != '0);

endmodule

//--- rtl/wai_top.sv
// Weld automation I/O: result/phase outputs, contact inputs, Avalon-MM registers.
// Assumes contact inputs are debounced, active high and synchronous to core_clk.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module wai_top
  import wai_pkg::*;
#(
  parameter int unsigned PULSE_CYC = HOLD_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [3:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  input  wire wai_contacts_type contacts,
  input  wire logic             start_req,
  input  wire logic             weld_done,
  input  wire logic             hold_done,
  input  wire logic             after_done,
  input  wire logic             home_done,
  input  wire logic             use_afterburst,
  input  wire logic             meas_valid,
  input  wire logic             meas_bad,
  input  wire logic             meas_suspect,
  output wai_outputs_type       sw_close,
  output wai_drive_type         drive,
  output logic                  error_212
);

  logic [31:0]    ctrl_r;
  logic [15:0]    part_count_r;
  logic [15:0]    error_code_r;
  wai_phase_type  phase_r;
  logic           bad_r;
  logic           suspect_r;
  logic           result_valid_r;
  logic           pulse_start_r;
  logic           pulse_busy;
  logic           ack_r;
  logic           ready_r;
  wai_outputs_type raw;
  wai_alt_type    alt_sel;
  wai_rdy_type    rdy_sel;
  logic           stop_any;
  logic           in_cycle;
  logic           sonics_on;
  logic           pulsed;
  logic           start_ok;
  logic           result_on;

  assign alt_sel  = wai_alt_type'(ctrl_r[CTRL_ALT_LSB +: 2]);
  assign rdy_sel  = wai_rdy_type'(ctrl_r[CTRL_RDY_LSB +: 2]);
  assign pulsed   = ctrl_r[CTRL_PULSED];
  assign stop_any = contacts.stop_no | ~contacts.stop_nc_closed;
  assign in_cycle = (phase_r != PH_IDLE);
  assign sonics_on = (phase_r == PH_WELD) | (phase_r == PH_AFTER);
  assign start_ok = start_req & ~stop_any & (phase_r == PH_IDLE);

  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Single wait state: every access answers on its second cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (avs_write && ack_r && avs_address == REG_CTRL) begin
      ctrl_r <= merge_be(ctrl_r, avs_writedata, avs_byteenable) & 32'h0000_007F;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      unique case (avs_address)
        REG_CTRL:   avs_readdata <= ctrl_r;
        REG_STATUS: avs_readdata <= {21'h0, error_212, phase_r, sw_close, ready_r, in_cycle, stop_any};
        REG_COUNT:  avs_readdata <= {16'h0, part_count_r};
        REG_ERROR:  avs_readdata <= {16'h0, error_code_r};
        default:    avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Weld sequence; stop aborts from any phase
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= PH_IDLE;
    end else if (stop_any) begin
      phase_r <= PH_IDLE;
    end else begin
      unique case (phase_r)
        PH_IDLE:  if (start_ok) phase_r <= PH_WELD;
        PH_WELD:  if (weld_done) phase_r <= PH_HOLD;
        PH_HOLD:  if (hold_done) phase_r <= use_afterburst ? PH_AFTER : PH_HOME;
        PH_AFTER: if (after_done) phase_r <= PH_HOME;
        PH_HOME:  if (home_done) phase_r <= PH_IDLE;
        default:  phase_r <= PH_IDLE;
      endcase
    end
  end

  // Ready is set at hold completion, before afterburst or press return
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ready_r <= 1'b0;
    end else if (start_ok || stop_any) begin
      ready_r <= 1'b0;
    end else if (phase_r == PH_HOLD && hold_done) begin
      ready_r <= 1'b1;
    end
  end

  // Initiate still closed at start is flagged; next clean start clears it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      error_212    <= 1'b0;
      error_code_r <= 16'h0000;
    end else if (start_ok) begin
      error_212    <= contacts.initiate;
      error_code_r <= contacts.initiate ? ERR_AUTO_ACTIVE : 16'h0000;
    end
  end

  // Limit crossings gathered over the sequence
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bad_r     <= 1'b0;
      suspect_r <= 1'b0;
    end else if (start_ok) begin
      bad_r     <= 1'b0;
      suspect_r <= 1'b0;
    end else if (in_cycle && meas_valid) begin
      bad_r     <= bad_r | meas_bad;
      suspect_r <= suspect_r | meas_suspect;
    end
  end

  // Result published at normal cycle end; aborted cycles publish nothing
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result_valid_r <= 1'b0;
      pulse_start_r  <= 1'b0;
    end else begin
      pulse_start_r <= 1'b0;
      if (start_ok || stop_any) begin
        result_valid_r <= 1'b0;
      end else if (phase_r == PH_HOME && home_done) begin
        result_valid_r <= 1'b1;
        pulse_start_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      part_count_r <= 16'h0000;
    end else if (!stop_any && phase_r == PH_HOME && home_done) begin
      part_count_r <= part_count_r + 16'h0001;
    end
  end

  wai_pulse_timer #(
    .CYCLES (PULSE_CYC)
  ) u_pulse (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (pulse_start_r),
    .busy     (pulse_busy)
  );

  assign result_on = pulsed ? pulse_busy : result_valid_r;

  always_comb begin
    raw.bad  = result_on & bad_r;
    raw.good = result_on & ~bad_r;
    unique case (alt_sel)
      ALT_SUSPECT:  raw.suspect_pos = result_on & suspect_r;
      ALT_IN_CYCLE: raw.suspect_pos = pulsed ? in_cycle : (in_cycle & ~ready_r);
      ALT_SONICS:   raw.suspect_pos = sonics_on;
      ALT_IN_HOLD:  raw.suspect_pos = (phase_r == PH_HOLD);
    endcase
    unique case (rdy_sel)
      RDY_NETWORK: raw.ready_pos = ctrl_r[CTRL_NET_ACT];
      RDY_SONICS:  raw.ready_pos = sonics_on;
      default:     raw.ready_pos = ready_r;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sw_close <= '0;
    end else begin
      sw_close <= ctrl_r[CTRL_POL_LOW] ? ~raw : raw;
    end
  end

  // Valves off on stop or inhibit; afterburst and return only after ready
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drive <= '0;
    end else begin
      drive.sonics       <= sonics_on & ~stop_any;
      drive.valves       <= in_cycle & (phase_r != PH_HOME) & ~stop_any & ~contacts.inhibit;
      drive.afterburst   <= (phase_r == PH_AFTER) & ready_r & ~stop_any;
      drive.press_return <= (phase_r == PH_HOME) & ready_r & ~stop_any & ~contacts.inhibit;
    end
  end

endmodule

//--- testbench/wai_sva.sv
// Port-level checks for the weld automation I/O block.
// Assumes binding to wai_top; contacts are synchronous levels.
`timescale 1ns/1ps
module wai_sva
  import wai_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             resetn,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic             avs_waitrequest,
  input wire wai_contacts_type contacts,
  input wire logic             start_req,
  input wire wai_drive_type    drive,
  input wire logic             error_212
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_req;
    $rose(avs_read) || $rose(avs_write);
  endsequence
  sequence s_stop3;
    (contacts.stop_no || !contacts.stop_nc_closed)[*3];
  endsequence
  AST_ACK_RISE: assert property (s_req |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("no answer in second cycle");
  AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  AST_ACK_IDLE: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  AST_VALVE_NO: assert property (contacts.stop_no[*3] |-> !drive.valves)
    else $error("valves on under open stop");
  AST_VALVE_NC: assert property (!contacts.stop_nc_closed[*3] |-> !drive.valves)
    else $error("valves on under closed stop");
  AST_VALVE_INH: assert property (contacts.inhibit[*3] |-> !drive.valves)
    else $error("valves on under inhibit");
  AST_SONIC_STOP: assert property (s_stop3 |-> !drive.sonics)
    else $error("cycle not ended by stop");
  AST_ERR_CAUSE: assert property ($changed(error_212) |-> $past(start_req) || $past(start_req, 2))
    else $error("error flag moved without start");
endmodule
bind wai_top wai_sva wai_sva_i (.core_clk(core_clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .contacts(contacts),
  .start_req(start_req), .drive(drive), .error_212(error_212));

//--- testbench/wai_auto_model.sv
// Automation side: initiate contact, start request, phase completions.
// Assumes GAP cycles between events; stuck keeps initiate closed.
`timescale 1ns/1ps
module wai_auto_model #(
  parameter int unsigned GAP = 8
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic go,
  input  wire logic stuck,
  output logic      initiate,
  output logic      start_req,
  output logic      weld_done,
  output logic      hold_done,
  output logic      after_done,
  output logic      home_done
);
  logic [7:0] step_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      step_r <= 8'h00;
      {initiate, start_req, weld_done, hold_done, after_done, home_done} <= 6'h00;
    end else begin
      step_r <= go ? 8'h01 : (step_r != 8'h00 && step_r < 5 * GAP) ? step_r + 8'h01 : 8'h00;
      // Scaled minimum closure, released before start
      initiate <= go || (initiate && (stuck || (step_r != 8'h00 && step_r < GAP)));
      start_req <= (step_r == GAP + 1);
      weld_done <= (step_r == 2 * GAP);
      hold_done <= (step_r == 3 * GAP);
      after_done <= (step_r == 4 * GAP);
      home_done <= (step_r == 5 * GAP);
    end
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench: Avalon register access and weld cycles.
// Assumes the automation model paces each cycle with fixed gaps.
`timescale 1ns/1ps
module tb;
  import wai_pkg::*;
  localparam int unsigned GAP = 8;
  localparam int unsigned PC  = 20;
  localparam logic [3:0]  W_X = 4'h6;
  localparam logic [3:0]  H_X = 4'hA;
  localparam logic [3:0]  A_X = 4'h4;
  logic            core_clk = 0, resetn = 0, rd = 0, wr = 0, go = 0, stk = 0;
  logic            sno = 0, ncc = 1, inh = 0, mb = 0, ms = 0, mv = 1, ua = 1, e212, wrq;
  logic [3:0]      adr = 0, be = 4'hF, sw_w, sw_h, sw_a;
  logic [31:0]     wdat = 0, q, rdat;
  logic            ini, sreq, wd_p, hd_p, ad_p, md_p;
  wai_outputs_type sw;
  wai_drive_type   dv, d_w, d_h, d_a, d_m;
  int              n_errors = 0, compares = 0, cnt = 0, tmo = 0;

  wai_top #(.PULSE_CYC(PC)) wai_top_i (.core_clk(core_clk), .resetn(resetn), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wrq), .contacts({ini, sno, ncc, inh}), .start_req(sreq), .weld_done(wd_p),
    .hold_done(hd_p), .after_done(ad_p), .home_done(md_p), .use_afterburst(ua), .meas_valid(mv),
    .meas_bad(mb), .meas_suspect(ms), .sw_close(sw), .drive(dv), .error_212(e212));
  wai_auto_model #(.GAP(GAP)) wai_auto_model_i (.core_clk(core_clk), .resetn(resetn), .go(go),
    .stuck(stk), .initiate(ini), .start_req(sreq), .weld_done(wd_p), .hold_done(hd_p),
    .after_done(ad_p), .home_done(md_p));

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (++tmo == 20000) begin
      n_errors++;
      $display("CHECK FAILED t=%0t timeout", $time);
      final_report();
    end
  end

  task automatic final_report();
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] b);
    @(posedge core_clk);
    adr <= a;
    wdat <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    // Only the bench timeout ends a wait for the answer
    do @(posedge core_clk); while (wrq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, 4'hF);
    chk(q, e);
  endtask
  // Stop kinds: 1 open stop, 2 closed stop, 3 inhibit; held well past minimum
  task automatic cyc(input int s);
    @(posedge core_clk) go <= 1'b1;
    @(posedge core_clk) go <= 1'b0;
    @(posedge wd_p) #1 sw_w = sw;
    d_w = dv;
    @(posedge core_clk);
    sno <= (s == 1);
    ncc <= (s != 2);
    inh <= (s == 3);
    @(posedge hd_p) #1 sw_h = sw;
    d_h = dv;
    @(posedge ad_p) #1 sw_a = sw;
    d_a = dv;
    @(posedge md_p) #1 d_m = dv;
    @(posedge core_clk);
    sno <= 1'b0;
    ncc <= 1'b1;
    inh <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rchk(REG_CTRL, CTRL_RESET);
    rchk(REG_COUNT, 32'h0);
    rchk(REG_ERROR, 32'h0);
    rchk(REG_STATUS, 32'h0);
    bus(4'hF, 1'b1, 32'hFFFF_FFFF, 4'hF);
    rchk(4'hF, 32'h0);
    bus(REG_CTRL, 1'b1, 32'hFFFF_FFFF, 4'h1);
    rchk(REG_CTRL, 32'h0000_007F);
    for (int f = 0; f < 4; f++) begin
      bus(REG_CTRL, 1'b1, 32'(f) << CTRL_ALT_LSB, 4'hF);
      cyc(0);
      cnt++;
      chk1(sw_w[2], W_X[f]);
      chk1(sw_h[2], H_X[f]);
      chk1(sw_a[2], A_X[f]);
      chk1(sw_w[1], 1'b0);
      chk1(d_w.valves, 1'b1);
      chk1(sw_a[0], 1'b1);
      chk1(d_a.afterburst, 1'b1);
      chk1(d_m.press_return, 1'b1);
      chk({29'h0, sw.bad, sw.suspect_pos, sw.good}, 32'h1);
    end
    bus(REG_CTRL, 1'b1, 32'h0, 4'hF);
    mb <= 1'b1;
    ms <= 1'b1;
    cyc(0);
    cnt++;
    chk({29'h0, sw.bad, sw.suspect_pos, sw.good}, 32'h6);
    @(posedge core_clk);
    mb <= 1'b0;
    ms <= 1'b0;
    for (int s = 1; s < 4; s++) begin
      cyc(s);
      cnt += (s == 3);
      chk1(d_h.valves, 1'b0);
      chk1(d_m.press_return, 1'b0);
      rchk(REG_COUNT, 32'(cnt));
    end
    // Limit flags without a measurement strobe must not count
    stk <= 1'b1;
    mb <= 1'b1;
    mv <= 1'b0;
    cyc(0);
    chk1(e212, 1'b1);
    chk({29'h0, sw.bad, sw.suspect_pos, sw.good}, 32'h1);
    rchk(REG_ERROR, 32'(ERR_AUTO_ACTIVE));
    stk <= 1'b0;
    mb <= 1'b0;
    mv <= 1'b1;
    ua <= 1'b0;
    cyc(0);
    chk1(e212, 1'b0);
    chk1(d_a.afterburst, 1'b0);
    chk1(d_a.press_return, 1'b1);
    bus(REG_CTRL, 1'b1, 32'h1, 4'hF);
    cyc(0);
    chk({29'h0, sw.bad, sw.suspect_pos, sw.good}, 32'h6);
    bus(REG_CTRL, 1'b1, 32'h2, 4'hF);
    cyc(0);
    chk1(sw.good, 1'b1);
    repeat (PC) @(posedge core_clk);
    #1 chk1(sw.good, 1'b0);
    bus(REG_CTRL, 1'b1, 32'h20, 4'hF);
    cyc(0);
    chk1(sw_w[0], 1'b1);
    chk1(sw_h[0], 1'b0);
    bus(REG_CTRL, 1'b1, 32'h50, 4'hF);
    repeat (3) @(posedge core_clk);
    #1 chk1(sw.ready_pos, 1'b1);
    bus(REG_CTRL, 1'b1, 32'h10, 4'hF);
    repeat (3) @(posedge core_clk);
    #1 chk1(sw.ready_pos, 1'b0);
    final_report();
  end
endmodule
